// >>> hdl/awu_alarm_watchdog.sv
`timescale 1ns/10ps
module awu_alarm_watchdog #(
  parameter int BASE_TICK_CYC = awu_pkg::BASE_TICK_CYC,
  parameter int TEST_HALF_CYC = awu_pkg::TEST_HALF_CYC,
  parameter int RESET_PULSE_CYC = awu_pkg::RESET_PULSE_CYC
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host sram-style pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [16:0] addr,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_oe,
  // timekeeping side
  input wire logic second_tick,
  input wire logic [3:0] field_equal,
  input wire logic osc_running,
  input wire logic on_backup,
  input wire logic power_up_pulse,
  // open-drain pins
  output logic irq_or_test_pin_n_o,
  output logic irq_or_test_pin_n_oe,
  output logic sys_reset_n_o,
  output logic sys_reset_n_oe,
  // status
  output logic freq_test_bit
);

  localparam awu_pkg::awu_cnt_t BASE_LAST = awu_pkg::awu_cnt_t'(BASE_TICK_CYC - 1);
  localparam awu_pkg::awu_cnt_t TEST_LAST = awu_pkg::awu_cnt_t'(TEST_HALF_CYC - 1);
  localparam awu_pkg::awu_cnt_t PULSE_LAST = awu_pkg::awu_cnt_t'(RESET_PULSE_CYC - 1);

  awu_pkg::awu_pins_s pins_raw;
  awu_pkg::awu_pins_s pins_meta;
  awu_pkg::awu_pins_s pins;
  awu_pkg::awu_access_s acc;
  awu_pkg::awu_access_s next_acc;

  logic acc_on;
  logic acc_start;
  logic acc_end;
  logic flags_start;
  logic flags_end;
  logic wdog_start;
  logic wdog_write_end;

  logic [7:0] irq_cfg;
  logic [7:0] next_irq_cfg;
  logic [7:0] wd_ctrl;
  logic [7:0] next_wd_ctrl;
  logic ft;
  logic next_ft;
  logic [3:0] masks;
  logic [3:0] next_masks;

  logic af;
  logic next_af;
  logic wf;
  logic next_wf;
  logic alarm_irq;
  logic next_alarm_irq;
  logic wd_irq;
  logic next_wd_irq;

  awu_pkg::awu_cnt_t pre_cnt;
  awu_pkg::awu_cnt_t next_pre_cnt;
  awu_pkg::awu_unit_t unit_cnt;
  awu_pkg::awu_unit_t next_unit_cnt;
  awu_pkg::awu_cnt_t pulse_cnt;
  awu_pkg::awu_cnt_t next_pulse_cnt;
  logic pulse_on;
  logic next_pulse_on;

  awu_pkg::awu_cnt_t sq_cnt;
  awu_pkg::awu_cnt_t next_sq_cnt;
  logic sq;
  logic next_sq;

  logic [7:0] next_dq_o;

  logic [4:0] wd_mult;
  logic [1:0] wd_gran;
  logic wd_route;
  awu_pkg::awu_unit_t wd_limit;
  logic wd_enabled;
  logic wd_restart;
  logic base_tick;
  logic timeout;
  logic pulse_end;
  logic mask_legal;
  logic alarm_hit;
  logic irq_allowed;
  logic test_on;
  logic read_sel;

  // pins come from the host's asynchronous bus
  assign pins_raw = '{ce_n: ce_n, oe_n: oe_n, we_n: we_n, addr: addr, data: dq_i};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pins_meta <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0};
      pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0};
    end
    else
    begin
      pins_meta <= pins_raw;
      pins <= pins_meta;
    end
  end

  // access tracking; an address change mid-access counts as a new access
  assign acc_on = !pins.ce_n && (!pins.oe_n || !pins.we_n);
  assign acc_start = acc_on && (!acc.active || pins.addr != acc.addr);
  assign acc_end = acc.active && (!acc_on || pins.addr != acc.addr);
  assign flags_start = acc_start && pins.addr == awu_pkg::FLAGS_ADDR;
  assign flags_end = acc_end && acc.addr == awu_pkg::FLAGS_ADDR;
  assign wdog_start = acc_start && pins.addr == awu_pkg::WDOG_ADDR;
  assign wdog_write_end = acc_end && acc.write && acc.addr == awu_pkg::WDOG_ADDR;

  always_comb
  begin
    next_acc = acc;
    next_acc.active = acc_on;
    if (acc_on)
    begin
      next_acc.write = !pins.we_n;
      next_acc.addr = pins.addr;
      if (!pins.we_n)
      begin
        next_acc.data = pins.data;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      acc <= '0;
    end
    else
    begin
      acc <= next_acc;
    end
  end

  // configuration registers; writes commit when the access ends
  assign wd_mult = wd_ctrl[awu_pkg::MULT_LSB +: awu_pkg::MULT_W];
  assign wd_gran = wd_ctrl[awu_pkg::GRAN_W - 1:0];
  assign wd_route = wd_ctrl[awu_pkg::ROUTE_BIT];

  always_comb
  begin
    next_irq_cfg = irq_cfg;
    next_wd_ctrl = wd_ctrl;
    next_ft = ft;
    next_masks = masks;
    if (acc_end && acc.write)
    begin
      unique case (acc.addr)
        awu_pkg::IRQ_CFG_ADDR: next_irq_cfg = acc.data;
        awu_pkg::WDOG_ADDR: next_wd_ctrl = acc.data;
        awu_pkg::DAY_ADDR: next_ft = acc.data[awu_pkg::FT_BIT];
        awu_pkg::ALM_SEC_ADDR: next_masks[0] = acc.data[awu_pkg::MASK_BIT];
        awu_pkg::ALM_MIN_ADDR: next_masks[1] = acc.data[awu_pkg::MASK_BIT];
        awu_pkg::ALM_HOUR_ADDR: next_masks[2] = acc.data[awu_pkg::MASK_BIT];
        awu_pkg::ALM_DATE_ADDR: next_masks[3] = acc.data[awu_pkg::MASK_BIT];
        default: next_masks = masks;
      endcase
    end
    if (pulse_end)
    begin
      next_wd_ctrl = awu_pkg::WDOG_RESET;
      next_ft = 1'b0;
    end
    if (power_up_pulse)
    begin
      next_irq_cfg[awu_pkg::AE_BIT] = 1'b0;
      next_irq_cfg[awu_pkg::ABE_BIT] = 1'b0;
      next_wd_ctrl = awu_pkg::WDOG_RESET;
      next_ft = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_cfg <= awu_pkg::IRQ_CFG_RESET;
      wd_ctrl <= awu_pkg::WDOG_RESET;
      ft <= 1'b0;
      masks <= awu_pkg::MASK_RESET;
    end
    else
    begin
      irq_cfg <= next_irq_cfg;
      wd_ctrl <= next_wd_ctrl;
      ft <= next_ft;
      masks <= next_masks;
    end
  end

  // alarm matching and flags
  always_comb
  begin
    unique case (masks)
      awu_pkg::MASK_EACH_SEC, awu_pkg::MASK_SEC, awu_pkg::MASK_MIN_SEC,
      awu_pkg::MASK_HMS, awu_pkg::MASK_DHMS: mask_legal = 1'b1;
      default: mask_legal = 1'b0;
    endcase
  end

  // a wrong mask fires every second so software notices
  assign alarm_hit = second_tick && (!mask_legal || &(field_equal | masks));
  // enables are being cleared during power-up, so that alarm only sets the flag
  assign irq_allowed = irq_cfg[awu_pkg::AE_BIT] && !power_up_pulse
                       && (!on_backup || irq_cfg[awu_pkg::ABE_BIT]);

  always_comb
  begin
    next_af = af;
    next_wf = wf;
    next_alarm_irq = alarm_irq;
    next_wd_irq = wd_irq;
    if (flags_end)
    begin
      next_af = 1'b0;
    end
    if (alarm_hit)
    begin
      next_af = 1'b1;
    end
    if (flags_start)
    begin
      next_alarm_irq = 1'b0;
    end
    if (alarm_hit && irq_allowed)
    begin
      next_alarm_irq = 1'b1;
    end
    if (flags_end && !acc.write)
    begin
      next_wf = 1'b0;
    end
    if ((flags_start && pins.we_n) || wdog_start)
    begin
      next_wd_irq = 1'b0;
    end
    if (timeout)
    begin
      next_wf = 1'b1;
    end
    // a reset-routed timeout must not drop an irq still pending from route 0
    if (timeout && !wd_route)
    begin
      next_wd_irq = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      af <= 1'b0;
      wf <= 1'b0;
      alarm_irq <= 1'b0;
      wd_irq <= 1'b0;
    end
    else
    begin
      af <= next_af;
      wf <= next_wf;
      alarm_irq <= next_alarm_irq;
      wd_irq <= next_wd_irq;
    end
  end

  // watchdog interval: granularity 0..3 gives 1, 4, 16, 64 base ticks of 1/16 s
  assign wd_limit = awu_pkg::awu_unit_t'({6'h00, wd_mult} << {wd_gran, 1'b0});
  assign wd_enabled = wd_mult != 5'h00;
  assign wd_restart = wdog_start || wdog_write_end;
  assign base_tick = osc_running && pre_cnt == BASE_LAST;
  assign timeout = wd_enabled && !pulse_on && !wd_restart && base_tick
                   && awu_pkg::awu_unit_t'(unit_cnt + 11'h001) == wd_limit;
  assign pulse_end = pulse_on && pulse_cnt == PULSE_LAST;

  always_comb
  begin
    next_pre_cnt = pre_cnt;
    next_unit_cnt = unit_cnt;
    next_pulse_cnt = pulse_cnt;
    next_pulse_on = pulse_on;
    if (wd_restart || !wd_enabled || pulse_on || timeout)
    begin
      next_pre_cnt = '0;
      next_unit_cnt = '0;
    end
    else if (osc_running)
    begin
      next_pre_cnt = base_tick ? '0 : awu_pkg::awu_cnt_t'(pre_cnt + 20'h00001);
      if (base_tick)
      begin
        next_unit_cnt = awu_pkg::awu_unit_t'(unit_cnt + 11'h001);
      end
    end
    if (pulse_on)
    begin
      next_pulse_cnt = awu_pkg::awu_cnt_t'(pulse_cnt + 20'h00001);
      if (pulse_end)
      begin
        next_pulse_on = 1'b0;
      end
    end
    else if (timeout && wd_route)
    begin
      next_pulse_on = 1'b1;
      next_pulse_cnt = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pre_cnt <= '0;
      unit_cnt <= '0;
      pulse_cnt <= '0;
      pulse_on <= 1'b0;
    end
    else
    begin
      pre_cnt <= next_pre_cnt;
      unit_cnt <= next_unit_cnt;
      pulse_cnt <= next_pulse_cnt;
      pulse_on <= next_pulse_on;
    end
  end

  // frequency test square wave; a pending watchdog irq suppresses it
  assign test_on = osc_running && ft && !irq_cfg[awu_pkg::AE_BIT]
                   && (wd_route || wd_ctrl == awu_pkg::WDOG_RESET) && !wd_irq;

  always_comb
  begin
    next_sq_cnt = '0;
    next_sq = 1'b0;
    if (test_on)
    begin
      next_sq = sq;
      next_sq_cnt = awu_pkg::awu_cnt_t'(sq_cnt + 20'h00001);
      if (sq_cnt == TEST_LAST)
      begin
        next_sq_cnt = '0;
        next_sq = !sq;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sq_cnt <= '0;
      sq <= 1'b0;
    end
    else
    begin
      sq_cnt <= next_sq_cnt;
      sq <= next_sq;
    end
  end

  // read port: only the flags, interrupt-enable and watchdog bytes are served here
  assign read_sel = !pins.ce_n && !pins.oe_n && pins.we_n
                    && (pins.addr == awu_pkg::FLAGS_ADDR || pins.addr == awu_pkg::IRQ_CFG_ADDR
                        || pins.addr == awu_pkg::WDOG_ADDR);

  always_comb
  begin
    next_dq_o = 8'h00;
    unique case (pins.addr)
      awu_pkg::FLAGS_ADDR:
      begin
        next_dq_o[awu_pkg::FLAG_WF_BIT] = wf;
        next_dq_o[awu_pkg::FLAG_AF_BIT] = af;
      end
      awu_pkg::IRQ_CFG_ADDR: next_dq_o = irq_cfg;
      awu_pkg::WDOG_ADDR: next_dq_o = wd_ctrl;
      default: next_dq_o = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dq_o <= 8'h00;
      dq_oe <= 1'b0;
    end
    else
    begin
      dq_o <= next_dq_o;
      dq_oe <= read_sel;
    end
  end

  // open-drain pins: the driven level is always low
  assign irq_or_test_pin_n_o = 1'b0;
  assign irq_or_test_pin_n_oe = alarm_irq || wd_irq || (test_on && sq);
  assign sys_reset_n_o = 1'b0;
  assign sys_reset_n_oe = pulse_on;
  assign freq_test_bit = ft;

endmodule // awu_alarm_watchdog

// >>> hdl/awu_pkg.sv
package awu_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;

  // register locations
  localparam logic [16:0] FLAGS_ADDR = 17'h1fff0;
  localparam logic [16:0] ALM_SEC_ADDR = 17'h1fff2;
  localparam logic [16:0] ALM_MIN_ADDR = 17'h1fff3;
  localparam logic [16:0] ALM_HOUR_ADDR = 17'h1fff4;
  localparam logic [16:0] ALM_DATE_ADDR = 17'h1fff5;
  localparam logic [16:0] IRQ_CFG_ADDR = 17'h1fff6;
  localparam logic [16:0] WDOG_ADDR = 17'h1fff7;
  localparam logic [16:0] DAY_ADDR = 17'h1fffc;

  // field positions
  localparam int FLAG_WF_BIT = 7;
  localparam int FLAG_AF_BIT = 6;
  localparam int AE_BIT = 7;
  localparam int ABE_BIT = 5;
  localparam int ROUTE_BIT = 7;
  localparam int MULT_LSB = 2;
  localparam int MULT_W = 5;
  localparam int GRAN_W = 2;
  localparam int FT_BIT = 6;
  localparam int MASK_BIT = 7;

  // reset values
  localparam logic [7:0] WDOG_RESET = 8'h00;
  localparam logic [7:0] IRQ_CFG_RESET = 8'h00;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // legal mask patterns, am4..am1
  localparam logic [3:0] MASK_EACH_SEC = 4'hf;
  localparam logic [3:0] MASK_SEC = 4'he;
  localparam logic [3:0] MASK_MIN_SEC = 4'hc;
  localparam logic [3:0] MASK_HMS = 4'h8;
  localparam logic [3:0] MASK_DHMS = 4'h0;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int BASE_TICK_NS = 62_500_000;
  localparam int BASE_TICK_CYC = BASE_TICK_NS / CLK_PERIOD_NS;
  localparam int TEST_FREQ_HZ = 512;
  localparam int TEST_HALF_CYC = CLK_HZ / (2 * TEST_FREQ_HZ);
  localparam int RESET_PULSE_MIN_MS = 40;
  localparam int RESET_PULSE_CYC = RESET_PULSE_MIN_MS * 1_000_000 / CLK_PERIOD_NS;

  typedef logic [19:0] awu_cnt_t;
  typedef logic [10:0] awu_unit_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [16:0] addr;
    logic [7:0] data;
  } awu_pins_s;

  typedef struct packed {
    logic active;
    logic write;
    logic [16:0] addr;
    logic [7:0] data;
  } awu_access_s;

endpackage

// >>> tb/awu_alarm_watchdog_chk.sv
`timescale 1ns/10ps
module awu_alarm_watchdog_chk #(
  parameter int RESET_PULSE_CYC = awu_pkg::RESET_PULSE_CYC
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [16:0] addr,
  input wire logic dq_oe,
  // open-drain pins and status
  input wire logic irq_or_test_pin_n_o,
  input wire logic irq_or_test_pin_n_oe,
  input wire logic sys_reset_n_o,
  input wire logic sys_reset_n_oe,
  input wire logic freq_test_bit
);
  logic fl_rd;
  logic srv_rd;
  logic [19:0] low_cnt;
  logic [19:0] next_low_cnt;
  assign fl_rd = !ce_n && !oe_n && addr == awu_pkg::FLAGS_ADDR;
  assign srv_rd = !ce_n && !oe_n && (fl_rd || addr == awu_pkg::IRQ_CFG_ADDR || addr == awu_pkg::WDOG_ADDR);
  // clocks spent with the reset pin pulled low
  always_comb
  begin
    next_low_cnt = (rst || !sys_reset_n_oe) ? 20'h00000 : low_cnt + 20'h00001;
  end
  always_ff @(posedge clk)
  begin
    low_cnt <= next_low_cnt;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_OD_IRQ: assert property (irq_or_test_pin_n_o == 1'b0)
    else $error("irq pin driven high");
  AST_OD_RST: assert property (sys_reset_n_o == 1'b0)
    else $error("reset pin driven high");
  AST_PULSE_LEN: assert property ($fell(sys_reset_n_oe) |-> low_cnt == RESET_PULSE_CYC)
    else $error("reset pulse width wrong");
  AST_RST_STATE: assert property ($fell(rst) |-> !dq_oe && !sys_reset_n_oe && !irq_or_test_pin_n_oe && !freq_test_bit)
    else $error("outputs active after reset");
  AST_RD_DRIVE: assert property ($rose(dq_oe) |-> $past(srv_rd, 2))
    else $error("data bus driven without a read");
  AST_DQ_RELEASE: assert property (ce_n [*5] |=> !dq_oe)
    else $error("data bus held after deselect");
  AST_FLAGS_RELEASE: assert property (fl_rd [*6] |=> !irq_or_test_pin_n_oe)
    else $error("irq held during flags read");
  AST_FT_CLEAR: assert property ($fell(sys_reset_n_oe) |-> ##[0:2] !freq_test_bit)
    else $error("test bit kept after reset pulse");
  cover property ($rose(sys_reset_n_oe));
  cover property (fl_rd && $fell(irq_or_test_pin_n_oe));
  cover property ($rose(dq_oe));
endmodule // awu_alarm_watchdog_chk

bind awu_alarm_watchdog awu_alarm_watchdog_chk #(.RESET_PULSE_CYC(RESET_PULSE_CYC)) i_awu_alarm_watchdog_chk (
  .clk, .rst, .ce_n, .oe_n, .we_n, .addr, .dq_oe, .irq_or_test_pin_n_o, .irq_or_test_pin_n_oe,
  .sys_reset_n_o, .sys_reset_n_oe, .freq_test_bit);

// >>> tb/awu_host_model.sv
`timescale 1ns/10ps
module awu_host_model (
  // clock
  input wire logic clk,
  // sram-style pins toward the device
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [16:0] addr,
  output logic [7:0] dq_i,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe
);
  initial
  begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    addr = 17'h00000;
    dq_i = 8'h5a;
  end
  // pins are resynchronised, so strobes stay low many clocks
  task automatic acc(input logic wr, input logic [16:0] a, input logic [7:0] d, input int hold,
                     output logic [7:0] q, output logic oe);
    @(posedge clk);
    addr <= a;
    dq_i <= wr ? d : ~d;
    ce_n <= 1'b0;
    oe_n <= wr;
    we_n <= !wr;
    repeat (hold) @(posedge clk);
    q = dq_o;
    oe = dq_oe;
    ce_n <= 1'b1;
    oe_n <= 1'b1;
    we_n <= 1'b1;
    // released data lines must not look like the last value
    dq_i <= ~d;
    repeat (4) @(posedge clk);
  endtask
endmodule // awu_host_model

// >>> tb/awu_alarm_watchdog_bench.sv
`timescale 1ns/10ps
module awu_alarm_watchdog_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic [16:0] addr;
  logic [7:0] dq_i;
  logic [7:0] dq_o;
  logic [7:0] q;
  logic q_oe;
  logic dq_oe;
  logic second_tick = 1'b0;
  logic osc_running = 1'b1;
  logic on_backup = 1'b0;
  logic power_up_pulse = 1'b0;
  logic [3:0] field_equal = 4'h0;
  logic irq_o;
  logic irq_oe;
  logic rst_o;
  logic rst_oe;
  logic ft;
  int err_total = 0;
  int n_tests = 0;
  int c;
  // pulled up when nobody sinks it
  wire irq_pin_n = irq_oe ? irq_o : 1'b1;
  wire rst_pin_n = rst_oe ? rst_o : 1'b1;

  always #50 clk = ~clk;

  awu_alarm_watchdog #(.BASE_TICK_CYC(4), .TEST_HALF_CYC(3), .RESET_PULSE_CYC(5)) i_awu_alarm_watchdog (
    .clk, .rst, .ce_n, .oe_n, .we_n, .addr, .dq_i, .dq_o, .dq_oe, .second_tick, .field_equal, .osc_running,
    .on_backup, .power_up_pulse, .irq_or_test_pin_n_o(irq_o), .irq_or_test_pin_n_oe(irq_oe),
    .sys_reset_n_o(rst_o), .sys_reset_n_oe(rst_oe), .freq_test_bit(ft));
  awu_host_model i_awu_host_model (.clk, .ce_n, .oe_n, .we_n, .addr, .dq_i, .dq_o, .dq_oe);

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [16:0] a);
    i_awu_host_model.acc(1'b0, a, 8'h00, 6, q, q_oe);
  endtask
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    i_awu_host_model.acc(1'b1, a, d, 6, q, q_oe);
  endtask
  task automatic tick();
    @(posedge clk);
    second_tick <= 1'b1;
    @(posedge clk);
    second_tick <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // counts changes of the irq pin drive over n clocks
  task automatic toggles(input int n);
    logic p;
    c = 0;
    @(negedge clk);
    p = irq_oe;
    repeat (n)
    begin
      @(negedge clk);
      if (irq_oe !== p)
        c++;
      p = irq_oe;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(awu_pkg::WDOG_ADDR);
    chk("wdog_init", q, 8'h00);
    rd(awu_pkg::IRQ_CFG_ADDR);
    chk("cfg_init", q, 8'h00);
    chk("ft_init", 8'(ft), 8'h00);
    wr(awu_pkg::IRQ_CFG_ADDR, 8'h80);
    chk("wr_no_drive", 8'(q_oe), 8'h00);
    field_equal <= 4'hf;
    tick();
    chk("irq_alarm", 8'(irq_pin_n), 8'h00);
    i_awu_host_model.acc(1'b0, awu_pkg::FLAGS_ADDR, 8'h00, 12, q, q_oe);
    chk("af_set", q, 8'h40);
    chk("irq_ack", 8'(irq_pin_n), 8'h01);
    rd(awu_pkg::FLAGS_ADDR);
    chk("af_clr", q, 8'h00);
    field_equal <= 4'h0;
    wr(awu_pkg::ALM_SEC_ADDR, 8'h80);
    tick();
    rd(awu_pkg::FLAGS_ADDR);
    chk("af_mask", q, 8'h40);
    wr(awu_pkg::ALM_SEC_ADDR, 8'h00);
    on_backup <= 1'b1;
    field_equal <= 4'hf;
    tick();
    chk("irq_bk_off", 8'(irq_pin_n), 8'h01);
    rd(awu_pkg::FLAGS_ADDR);
    wr(awu_pkg::IRQ_CFG_ADDR, 8'ha0);
    tick();
    chk("irq_bk_on", 8'(irq_pin_n), 8'h00);
    wr(awu_pkg::FLAGS_ADDR, 8'h00);
    chk("irq_wr_ack", 8'(irq_pin_n), 8'h01);
    on_backup <= 1'b0;
    @(posedge clk);
    power_up_pulse <= 1'b1;
    second_tick <= 1'b1;
    @(posedge clk);
    power_up_pulse <= 1'b0;
    second_tick <= 1'b0;
    field_equal <= 4'h0;
    rd(awu_pkg::IRQ_CFG_ADDR);
    chk("cfg_pwrup", q, 8'h00);
    chk("irq_pwrup", 8'(irq_pin_n), 8'h01);
    rd(awu_pkg::FLAGS_ADDR);
    chk("af_pwrup", q, 8'h40);
    // three quarter-second units: 48 clocks at the shortened base tick
    wr(awu_pkg::WDOG_ADDR, 8'h0d);
    repeat (40) @(posedge clk);
    chk("wd_early", 8'(irq_pin_n), 8'h01);
    repeat (16) @(posedge clk);
    chk("wd_irq", 8'(irq_pin_n), 8'h00);
    wr(awu_pkg::WDOG_ADDR, 8'h05);
    chk("wd_wr_ack", 8'(irq_pin_n), 8'h01);
    repeat (6) rd(awu_pkg::WDOG_ADDR);
    chk("wd_serviced", 8'(irq_pin_n), 8'h01);
    chk("wd_rd", q, 8'h05);
    chk("rd_drive", 8'(q_oe), 8'h01);
    wr(awu_pkg::WDOG_ADDR, 8'h00);
    rd(awu_pkg::FLAGS_ADDR);
    chk("wf_set", q, 8'h80);
    repeat (100) @(posedge clk);
    chk("wd_off", 8'(irq_pin_n), 8'h01);
    wr(awu_pkg::DAY_ADDR, 8'h40);
    toggles(60);
    chk("wave", 8'(c inside {[19:21]}), 8'h01);
    // a stopped oscillator must silence the test wave
    @(posedge clk);
    osc_running <= 1'b0;
    toggles(30);
    chk("wave_osc_off", 8'(c), 8'h00);
    @(posedge clk);
    osc_running <= 1'b1;
    wr(awu_pkg::WDOG_ADDR, 8'h04);
    repeat (10) @(posedge clk);
    toggles(30);
    chk("wave_denied", 8'(c), 8'h00);
    chk("wd_irq_or_test_pin", 8'(irq_pin_n), 8'h00);
    wr(awu_pkg::WDOG_ADDR, 8'h84);
    c = 0;
    repeat (100)
    begin
      @(negedge clk);
      if (rst_pin_n === 1'b0)
        c++;
    end
    chk("rst_pulse", 8'(c), 8'h05);
    rd(awu_pkg::WDOG_ADDR);
    chk("wd_cleared", q, 8'h00);
    chk("ft_cleared", 8'(ft), 8'h00);
    report_and_stop();
  end

  initial
  begin
    #1_000_000;
    err_total++;
    report_and_stop();
  end
endmodule // awu_alarm_watchdog_bench
